// [dv/mcr_host_model.sv]
// Behavioural bus host that issues command requests to the register bank.
module mcr_host_model (
   // Clock.
   input wire logic clk,
   // Command request.
   output logic cmdValid,
   output logic cmdWrite,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdData
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdCode = 8'h00;
      cmdData = 16'h0000;
   end

   // Offset words are sent exactly as given, whatever exponent they carry.
   // Pin reassignment is sent whenever asked, whatever the output is doing.
   task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdWrite <= wr;
      cmdCode <= code;
      cmdData <= data;
   endtask

   // Released lines flip, so stale values can never pass for a fresh request.
   task automatic idle();
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdWrite <= ~cmdWrite;
      cmdCode <= ~cmdCode;
      cmdData <= ~cmdData;
   endtask
endmodule // mcr_host_model

// [dv/mcr_regs_tb.sv]
// Self-checking testbench of the calibration register bank.
`include "mcr_cfg.svh"
module mcr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] NAME = 6'h2a;
   localparam logic [7:0] FW = 8'h11;
   localparam logic [15:0] GAIN_TRY [6] = '{16'h1999, 16'h2666, 16'h1998, 16'h2667,
      16'h0000, 16'hffff};
   localparam mcr_pkg::mcr_pin_fn_t FIRST_FN [3] = '{mcr_pkg::MCR_FN_ONOFF,
      mcr_pkg::MCR_FN_TRIM, mcr_pkg::MCR_FN_TRIM};
   localparam mcr_pkg::mcr_pin_fn_t SECOND_FN [3] = '{mcr_pkg::MCR_FN_POWER_GOOD,
      mcr_pkg::MCR_FN_POWER_GOOD, mcr_pkg::MCR_FN_ONOFF};
   logic clk, rst, cmdValid, cmdWrite, rspValid, writeProtectEnable, nvmWrite;
   logic busAlertLineN, respondAraOnly, respondOwnAddr;
   logic [7:0] cmdCode, nvmCode;
   logic [15:0] cmdData, rspData, voutGain, voutOffset, vinGain, vinOffset;
   logic [15:0] ioutGain, ioutOffset, nvmData, rnd, pinShadow;
   mcr_pkg::mcr_rsp_t rspStatus;
   mcr_pkg::mcr_pin_fn_t firstPinFn, secondPinFn;
   logic [17:0] note;
   logic [17:0] expQ [$];
   logic [15:0] shadow [logic [7:0]];
   int bad_count = 0, compares = 0, nvmSeen = 0, nvmExp = 0, cycles = 0;

   mcr_regs #(.MODULE_NAME(NAME), .FW_REVISION(FW)) dut (.clk(clk), .rst(rst),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
      .rspValid(rspValid), .rspData(rspData), .rspStatus(rspStatus), .voutGain(voutGain),
      .voutOffset(voutOffset), .vinGain(vinGain), .vinOffset(vinOffset),
      .ioutGain(ioutGain), .ioutOffset(ioutOffset), .writeProtectEnable(writeProtectEnable),
      .nvmWrite(nvmWrite), .nvmCode(nvmCode), .nvmData(nvmData),
      .busAlertLineN(busAlertLineN), .respondAraOnly(respondAraOnly),
      .respondOwnAddr(respondOwnAddr), .firstPinFn(firstPinFn), .secondPinFn(secondPinFn));
   mcr_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdData(cmdData));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Writes note the expected response and mirror what an accepted calibration word should leave behind.
   task automatic wr(input logic [7:0] code, input logic [15:0] data, input mcr_pkg::mcr_rsp_t st);
      host.send(1'b1, code, data);
      expQ.push_back({st, 16'h0000});
      if (st == mcr_pkg::MCR_RSP_OK && code inside {[8'hd1:8'hd6]})
      begin
         nvmExp++;
         shadow[code] = data;
      end
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      host.send(1'b0, code, 16'($urandom));
      expQ.push_back({mcr_pkg::MCR_RSP_OK, exp});
   endtask

   task automatic settle(input int n);
      repeat (n) host.idle();
      #1;
   endtask

   // Responses are matched in order against the oldest note.
   always @(posedge clk)
   begin
      cycles++;
      if (nvmWrite === 1'b1)
         nvmSeen++;
      if (rspValid === 1'b1)
      begin
         if (expQ.size() == 0)
            check("spare response", 16'h0001, 16'h0000);
         else
         begin
            note = expQ.pop_front();
            check("status", 16'(rspStatus), {14'h0, note[17:16]});
            check("read data", rspData, note[15:0]);
         end
      end
      if (cycles == 3000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   initial
   begin
      void'($urandom(18));
      rst = 1'b1;
      busAlertLineN = 1'b1;
      shadow[`MCR_CMD_VOUT_GAIN] = `MCR_GAIN_RST;
      shadow[`MCR_CMD_VIN_GAIN] = `MCR_GAIN_RST;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(`MCR_CMD_IDENTITY, {8'h00, NAME, 2'b10});
      rd(`MCR_CMD_VOUT_GAIN, `MCR_GAIN_RST);
      rd(`MCR_CMD_VIN_GAIN, `MCR_GAIN_RST);
      rd(`MCR_CMD_FW_REV, {8'h00, FW});
      rd(`MCR_CMD_PIN_CFG, 16'h0000);
      for (int c = 8'hd1; c <= 8'hd6; c++)
         wr(8'(c), 16'($urandom), mcr_pkg::MCR_RSP_LOCKED);
      rd(`MCR_CMD_VIN_GAIN, `MCR_GAIN_RST);
      settle(1);
      check("protect", {15'h0, writeProtectEnable}, 16'h0001);
      check("own address", {15'h0, respondOwnAddr}, 16'h0001);
      rnd = 16'($urandom) & 16'hfffd;
      wr(`MCR_CMD_IDENTITY, rnd, mcr_pkg::MCR_RSP_OK);
      rd(`MCR_CMD_IDENTITY, {8'h00, NAME, 2'b00});
      foreach (GAIN_TRY[i])
         wr(`MCR_CMD_VOUT_GAIN, GAIN_TRY[i], (GAIN_TRY[i] >= `MCR_VOUT_GAIN_MIN &&
            GAIN_TRY[i] <= `MCR_VOUT_GAIN_MAX) ? mcr_pkg::MCR_RSP_OK :
            mcr_pkg::MCR_RSP_INVALID);
      rd(`MCR_CMD_VOUT_GAIN, shadow[`MCR_CMD_VOUT_GAIN]);
      rnd = 16'($urandom);
      wr(`MCR_CMD_VOUT_OFFSET, {5'h14, rnd[10:0]}, mcr_pkg::MCR_RSP_OK);
      wr(`MCR_CMD_VOUT_OFFSET, {5'h13, rnd[10:0]}, mcr_pkg::MCR_RSP_INVALID);
      wr(`MCR_CMD_VOUT_OFFSET, {5'h15, ~rnd[10:0]}, mcr_pkg::MCR_RSP_INVALID);
      for (int c = 8'hd3; c <= 8'hd6; c++)
         wr(8'(c), 16'($urandom), mcr_pkg::MCR_RSP_OK);
      settle(1);
      check("nvm code", {8'h00, nvmCode}, 16'h00d6);
      check("nvm data", nvmData, shadow[8'hd6]);
      check("vout gain", voutGain, shadow[8'hd1]);
      check("vout offset", voutOffset, shadow[8'hd2]);
      check("vin gain", vinGain, shadow[8'hd3]);
      check("vin offset", vinOffset, shadow[8'hd4]);
      check("iout gain", ioutGain, shadow[8'hd5]);
      check("iout offset", ioutOffset, shadow[8'hd6]);
      for (int c = 8'hd1; c <= 8'hd6; c++)
         rd(8'(c), shadow[8'(c)]);
      wr(`MCR_CMD_FW_REV, 16'($urandom), mcr_pkg::MCR_RSP_INVALID);
      rd(`MCR_CMD_FW_REV, {8'h00, FW});
      pinShadow = 16'h0000;
      for (int c = 0; c < 16; c++)
      begin
         rnd = 16'($urandom);
         wr(`MCR_CMD_PIN_CFG, {8'h00, rnd[7:4], 4'(c)},
            (c <= 2) ? mcr_pkg::MCR_RSP_OK : mcr_pkg::MCR_RSP_INVALID);
         if (c <= 2)
            pinShadow = {11'h000, rnd[4], 4'(c)};
         settle(2);
         check("first pin", 16'(firstPinFn), 16'(FIRST_FN[pinShadow[1:0]]));
         check("second pin", 16'(secondPinFn), 16'(SECOND_FN[pinShadow[1:0]]));
         rd(`MCR_CMD_PIN_CFG, pinShadow);
      end
      for (int a = 1; a >= 0; a--)
      begin
         wr(`MCR_CMD_PIN_CFG, {11'h000, 1'(a), 4'h0}, mcr_pkg::MCR_RSP_OK);
         host.idle();
         busAlertLineN <= 1'b0;
         settle(4);
         check("ara only", {15'h0, respondAraOnly}, 16'(a));
         check("own address", {15'h0, respondOwnAddr}, 16'(1 - a));
         busAlertLineN <= 1'b1;
      end
      wr(8'hd7, 16'($urandom), mcr_pkg::MCR_RSP_UNSUPPORTED);
      wr(`MCR_CMD_IDENTITY, 16'hff02, mcr_pkg::MCR_RSP_OK);
      wr(`MCR_CMD_VIN_OFFSET, 16'($urandom), mcr_pkg::MCR_RSP_LOCKED);
      rd(`MCR_CMD_VIN_OFFSET, shadow[8'hd4]);
      rd(`MCR_CMD_IDENTITY, {8'h00, NAME, 2'b10});
      settle(3);
      check("unanswered", 16'(expQ.size()), 16'h0000);
      check("persist count", 16'(nvmSeen), 16'(nvmExp));
      give_verdict();
   end
endmodule // mcr_regs_tb

// [inc/mcr_cfg.svh]
// Command codes, field positions, reset values and limits of the calibration register bank.
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// Command codes.
`define MCR_CMD_IDENTITY 8'hd0
`define MCR_CMD_VOUT_GAIN 8'hd1
`define MCR_CMD_VOUT_OFFSET 8'hd2
`define MCR_CMD_VIN_GAIN 8'hd3
`define MCR_CMD_VIN_OFFSET 8'hd4
`define MCR_CMD_IOUT_GAIN 8'hd5
`define MCR_CMD_IOUT_OFFSET 8'hd6
`define MCR_CMD_FW_REV 8'hdb
`define MCR_CMD_PIN_CFG 8'he0

// Identity word fields.
`define MCR_WPE_BIT 1
`define MCR_NAME_MSB 7
`define MCR_NAME_LSB 2
`define MCR_WPE_RST 1'b1

// Calibration defaults and limits.
`define MCR_GAIN_RST 16'h2000
`define MCR_VOUT_GAIN_MAX 16'h2666
`define MCR_VOUT_GAIN_MIN 16'h1999
`define MCR_OFFSET_RST 16'h0000
`define MCR_EXP_MSB 15
`define MCR_EXP_LSB 11
`define MCR_VOUT_OFS_EXP 5'h14

// Pin configuration byte.
`define MCR_ARA_BIT 4
`define MCR_PIN_MSB 3
`define MCR_PIN_LSB 0
`define MCR_PINCFG_RST 5'h00
`define MCR_PIN_ONOFF_PG 4'h0
`define MCR_PIN_TRIM_PG 4'h1
`define MCR_PIN_TRIM_ONOFF 4'h2

`endif

// [inc/mcr_pin_if.sv]
// Carrier between the register bank and the multi-purpose pin decoder.
interface mcr_pin_if;
   logic [3:0] code;
   mcr_pkg::mcr_pin_fn_t firstFn;
   mcr_pkg::mcr_pin_fn_t secondFn;
   logic legal;
   modport cfg(output code, input firstFn, input secondFn, input legal);
   modport decode(input code, output firstFn, output secondFn, output legal);
endinterface

// [inc/mcr_pkg.sv]
// Types and shared decode functions of the calibration register bank.
package mcr_pkg;
   `include "mcr_cfg.svh"

   typedef enum logic [1:0] {
      MCR_RSP_OK = 2'h0,
      MCR_RSP_UNSUPPORTED = 2'h1,
      MCR_RSP_LOCKED = 2'h2,
      MCR_RSP_INVALID = 2'h3
   } mcr_rsp_t;

   typedef enum logic [1:0] {
      MCR_FN_ONOFF = 2'h0,
      MCR_FN_TRIM = 2'h1,
      MCR_FN_POWER_GOOD = 2'h2,
      MCR_FN_NONE = 2'h3
   } mcr_pin_fn_t;

   // Droop-sharing builds accept only the default assignment.
   function automatic logic mcr_pin_legal(input logic [3:0] code, input logic droop);
      mcr_pin_legal = (code == `MCR_PIN_ONOFF_PG) ||
         (!droop && ((code == `MCR_PIN_TRIM_PG) || (code == `MCR_PIN_TRIM_ONOFF)));
   endfunction
endpackage

// [verilog/mcr_pin_decode.sv]
// Decoder from the pin assignment code to the function of each multi-purpose pin.
`include "mcr_cfg.svh"
module mcr_pin_decode #(
   parameter bit DROOP_OPTION = 1'b0
) (
   mcr_pin_if.decode pins
);
   always_comb
   begin
      pins.legal = mcr_pkg::mcr_pin_legal(pins.code, DROOP_OPTION);
      pins.firstFn = mcr_pkg::MCR_FN_NONE;
      pins.secondFn = mcr_pkg::MCR_FN_NONE;
      if (pins.legal)
      begin
         unique case (pins.code)
            `MCR_PIN_ONOFF_PG:
            begin
               pins.firstFn = mcr_pkg::MCR_FN_ONOFF;
               pins.secondFn = mcr_pkg::MCR_FN_POWER_GOOD;
            end
            `MCR_PIN_TRIM_PG:
            begin
               pins.firstFn = mcr_pkg::MCR_FN_TRIM;
               pins.secondFn = mcr_pkg::MCR_FN_POWER_GOOD;
            end
            `MCR_PIN_TRIM_ONOFF:
            begin
               pins.firstFn = mcr_pkg::MCR_FN_TRIM;
               pins.secondFn = mcr_pkg::MCR_FN_ONOFF;
            end
            default:
            begin
               pins.firstFn = mcr_pkg::MCR_FN_NONE;
               pins.secondFn = mcr_pkg::MCR_FN_NONE;
            end
         endcase
      end
   end
endmodule // mcr_pin_decode

// [verilog/mcr_regs.sv]
// Manufacturer calibration, identity and pin configuration command registers.
`include "mcr_cfg.svh"
//
// Summary of operation
// - Bit 1 of the identity low byte is the write-protect enable, 1 meaning protected.
// - While write protect is set, every calibration gain and offset write is refused.
// - The output-voltage gain resets to 0x2000 and only values from 0x1999 to 0x2666 are kept.
// - The output-voltage offset must carry exponent -12 and is persisted to nonvolatile storage.
// - The input-voltage gain resets to 0x2000 and is persisted to nonvolatile storage.
// - The input-voltage offset is held in input-voltage linear format and persisted.
// - The firmware revision is an eight-bit read-only value.
// - Pin byte bit 4 set makes the module answer only the alert response address during alert.
// - Pin codes 0000, 0001 and 0010 assign on/off+power-good, trim+power-good, trim+on/off.
// - Droop-sharing builds accept only pin code 0000.
// - Identity low byte bits 7:2 report the six-bit module designation.
// - Pin byte bits 7:5 read zero and ignore writes, bits 4:0 take a write only when bits 3:0 hold an accepted pin code, reset is zero.
module mcr_regs #(
   // Arbitrary designation, leading 1 marks an isolated product.
   parameter logic [5:0] MODULE_NAME = 6'h2a,
   // Arbitrary revision value.
   parameter logic [7:0] FW_REVISION = 8'h11,
   parameter bit DROOP_OPTION = 1'b0,
   parameter logic [15:0] VOUT_OFFSET_RST = `MCR_OFFSET_RST,
   parameter logic [15:0] VIN_OFFSET_RST = `MCR_OFFSET_RST,
   parameter logic [15:0] IOUT_GAIN_RST = `MCR_GAIN_RST,
   parameter logic [15:0] IOUT_OFFSET_RST = `MCR_OFFSET_RST
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Command port from the bus protocol engine.
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdData,
   // Response to the protocol engine.
   output logic rspValid,
   output logic [15:0] rspData,
   output mcr_pkg::mcr_rsp_t rspStatus,
   // Calibration factors and write-protect state to the readback path.
   output logic [15:0] voutGain,
   output logic [15:0] voutOffset,
   output logic [15:0] vinGain,
   output logic [15:0] vinOffset,
   output logic [15:0] ioutGain,
   output logic [15:0] ioutOffset,
   output logic writeProtectEnable,
   // Persist request to the nonvolatile store.
   output logic nvmWrite,
   output logic [7:0] nvmCode,
   output logic [15:0] nvmData,
   // Alert line and address selection.
   input wire logic busAlertLineN,
   output logic respondAraOnly,
   output logic respondOwnAddr,
   // Multi-purpose pin functions.
   output mcr_pkg::mcr_pin_fn_t firstPinFn,
   output mcr_pkg::mcr_pin_fn_t secondPinFn
);

   localparam int NCAL = 6;
   localparam logic [2:0] NO_CAL = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Decode helpers.

   function automatic logic [2:0] calIndex(input logic [7:0] code);
      unique case (code)
         `MCR_CMD_VOUT_GAIN: calIndex = 3'h0;
         `MCR_CMD_VOUT_OFFSET: calIndex = 3'h1;
         `MCR_CMD_VIN_GAIN: calIndex = 3'h2;
         `MCR_CMD_VIN_OFFSET: calIndex = 3'h3;
         `MCR_CMD_IOUT_GAIN: calIndex = 3'h4;
         `MCR_CMD_IOUT_OFFSET: calIndex = 3'h5;
         default: calIndex = NO_CAL;
      endcase
   endfunction

   function automatic logic calDataOk(input logic [2:0] idx, input logic [15:0] data);
      calDataOk = 1'b1;
      if (idx == 3'h0)
      begin
         calDataOk = (data >= `MCR_VOUT_GAIN_MIN) && (data <= `MCR_VOUT_GAIN_MAX);
      end
      else if (idx == 3'h1)
      begin
         calDataOk = data[`MCR_EXP_MSB:`MCR_EXP_LSB] == `MCR_VOUT_OFS_EXP;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Write qualification.

   // Reset images are constants so the asynchronous reset branch loads no logic values.
   localparam logic [15:0] CAL_RST [NCAL] = '{`MCR_GAIN_RST, VOUT_OFFSET_RST, `MCR_GAIN_RST,
      VIN_OFFSET_RST, IOUT_GAIN_RST, IOUT_OFFSET_RST};

   logic [15:0] calWord [0:NCAL-1];
   logic write_protect_enable;
   logic [4:0] pinCfg;
   logic alertSync1;
   logic alertSync2;
   logic isWrite;
   logic [2:0] calIdx;
   logic calAccept;
   logic pinAccept;
   mcr_pin_if pinBus ();

   assign isWrite = cmdValid && cmdWrite;
   assign calIdx = calIndex(cmdCode);
   // Protection gates every calibration word, the identity word itself stays writable.
   assign calAccept = isWrite && (calIdx != NO_CAL) && !write_protect_enable &&
      calDataOk(calIdx, cmdData);
   // Reassignment is taken whatever the output is doing, and no glitch guard is kept here.
   assign pinAccept = isWrite && (cmdCode == `MCR_CMD_PIN_CFG) &&
      mcr_pkg::mcr_pin_legal(cmdData[`MCR_PIN_MSB:`MCR_PIN_LSB], DROOP_OPTION);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Storage.

   // Reset restores the factory defaults; the nonvolatile store reloads its image over the
   // command port after boot.
   genvar gi;
   generate
      for (gi = 0; gi < NCAL; gi++)
      begin : g_cal
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               calWord[gi] <= CAL_RST[gi];
            end
            else if (calAccept && (calIdx == 3'(gi)))
            begin
               calWord[gi] <= cmdData;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         write_protect_enable <= `MCR_WPE_RST;
      end
      else if (isWrite && (cmdCode == `MCR_CMD_IDENTITY))
      begin
         write_protect_enable <= cmdData[`MCR_WPE_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinCfg <= `MCR_PINCFG_RST;
      end
      else if (pinAccept)
      begin
         pinCfg <= cmdData[`MCR_ARA_BIT:`MCR_PIN_LSB];
      end
   end

   assign voutGain = calWord[0];
   assign voutOffset = calWord[1];
   assign vinGain = calWord[2];
   assign vinOffset = calWord[3];
   assign ioutGain = calWord[4];
   assign ioutOffset = calWord[5];
   assign writeProtectEnable = write_protect_enable;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Response.

   logic [15:0] next_rspData;
   mcr_pkg::mcr_rsp_t next_rspStatus;

   always_comb
   begin
      next_rspData = 16'h0000;
      next_rspStatus = mcr_pkg::MCR_RSP_OK;
      if (calIdx != NO_CAL)
      begin
         next_rspData = calWord[calIdx];
         if (cmdWrite && write_protect_enable)
         begin
            next_rspStatus = mcr_pkg::MCR_RSP_LOCKED;
         end
         else if (cmdWrite && !calDataOk(calIdx, cmdData))
         begin
            next_rspStatus = mcr_pkg::MCR_RSP_INVALID;
         end
      end
      else if (cmdCode == `MCR_CMD_IDENTITY)
      begin
         next_rspData = {8'h00, MODULE_NAME, write_protect_enable, 1'b0};
      end
      else if (cmdCode == `MCR_CMD_FW_REV)
      begin
         next_rspData = {8'h00, FW_REVISION};
         if (cmdWrite)
         begin
            next_rspStatus = mcr_pkg::MCR_RSP_INVALID;
         end
      end
      else if (cmdCode == `MCR_CMD_PIN_CFG)
      begin
         next_rspData = {8'h00, 3'h0, pinCfg};
         if (cmdWrite && !pinAccept)
         begin
            next_rspStatus = mcr_pkg::MCR_RSP_INVALID;
         end
      end
      else
      begin
         next_rspStatus = mcr_pkg::MCR_RSP_UNSUPPORTED;
      end
      // Writes echo nothing back, which keeps stale data off the bus.
      if (cmdWrite)
      begin
         next_rspData = 16'h0000;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rspValid <= 1'b0;
         rspData <= 16'h0000;
         rspStatus <= mcr_pkg::MCR_RSP_OK;
      end
      else
      begin
         rspValid <= cmdValid;
         if (cmdValid)
         begin
            rspData <= next_rspData;
            rspStatus <= next_rspStatus;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Nonvolatile persist request.

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         nvmWrite <= 1'b0;
         nvmCode <= 8'h00;
         nvmData <= 16'h0000;
      end
      else
      begin
         nvmWrite <= calAccept;
         if (calAccept)
         begin
            nvmCode <= cmdCode;
            nvmData <= cmdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Alert response address selection and pin functions.

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alertSync1 <= 1'b0;
         alertSync2 <= 1'b0;
      end
      else
      begin
         alertSync1 <= !busAlertLineN;
         alertSync2 <= alertSync1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         respondAraOnly <= 1'b0;
         respondOwnAddr <= 1'b1;
      end
      else
      begin
         respondAraOnly <= alertSync2 && pinCfg[`MCR_ARA_BIT];
         respondOwnAddr <= !(alertSync2 && pinCfg[`MCR_ARA_BIT]);
      end
   end

   assign pinBus.code = pinCfg[`MCR_PIN_MSB:`MCR_PIN_LSB];

   mcr_pin_decode #(
      .DROOP_OPTION(DROOP_OPTION)
   ) u_pinDecode (
      .pins(pinBus)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         firstPinFn <= mcr_pkg::MCR_FN_ONOFF;
         secondPinFn <= mcr_pkg::MCR_FN_POWER_GOOD;
      end
      else
      begin
         firstPinFn <= pinBus.firstFn;
         secondPinFn <= pinBus.secondFn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_wr(logic [7:0] code);
      cmdValid && cmdWrite && (cmdCode == code);
   endsequence

   sequence s_rd(logic [7:0] code);
      cmdValid && !cmdWrite && (cmdCode == code);
   endsequence

   property p_wpeRead;
      @(posedge clk) disable iff (rst)
      s_rd(`MCR_CMD_IDENTITY) |=> rspValid && (rspData[1] == write_protect_enable) && (rspData[0] == 1'b0);
   endproperty
   a_wpeRead: assert property (p_wpeRead) else $error("protect bit misread");

   property p_lockout;
      @(posedge clk) disable iff (rst)
      (cmdValid && cmdWrite && (calIdx != NO_CAL) && write_protect_enable) |=>
         !nvmWrite && (rspStatus == mcr_pkg::MCR_RSP_LOCKED) && $stable(calWord[0]) &&
         $stable(calWord[5]);
   endproperty
   a_lockout: assert property (p_lockout) else $error("protected calibration written");

   property p_voutGainRange;
      @(posedge clk) disable iff (rst)
      (voutGain >= 16'h1999) && (voutGain <= 16'h2666);
   endproperty
   a_voutGainRange: assert property (p_voutGainRange) else $error("gain out of range");

   property p_voutOfsExp;
      @(posedge clk) disable iff (rst)
      s_wr(`MCR_CMD_VOUT_OFFSET) ##0 (cmdData[15:11] != 5'h14) |=>
         (rspStatus != mcr_pkg::MCR_RSP_OK) && !nvmWrite;
   endproperty
   a_voutOfsExp: assert property (p_voutOfsExp) else $error("bad exponent accepted");

   property p_vinGainPersist;
      @(posedge clk) disable iff (rst)
      s_wr(`MCR_CMD_VIN_GAIN) ##0 !write_protect_enable |=>
         nvmWrite && (nvmCode == 8'hd3) && (vinGain == nvmData) ##1
         (!nvmWrite || $past(isWrite));
   endproperty
   a_vinGainPersist: assert property (p_vinGainPersist) else $error("gain not kept");

   property p_fwRead;
      @(posedge clk) disable iff (rst)
      s_rd(`MCR_CMD_FW_REV) |=> (rspData == {8'h00, FW_REVISION}) &&
         (rspStatus == mcr_pkg::MCR_RSP_OK);
   endproperty
   a_fwRead: assert property (p_fwRead) else $error("revision misread");

   property p_ara;
      @(posedge clk) disable iff (rst)
      (!busAlertLineN && pinCfg[4]) [*3] |=> respondAraOnly && !respondOwnAddr;
   endproperty
   a_ara: assert property (p_ara) else $error("alert address not taken");

   property p_pinDecode;
      @(posedge clk) disable iff (rst)
      (pinCfg[3:0] == 4'h1) |=> (firstPinFn == mcr_pkg::MCR_FN_TRIM) &&
         (secondPinFn == mcr_pkg::MCR_FN_POWER_GOOD);
   endproperty
   a_pinDecode: assert property (p_pinDecode) else $error("pin code misdecoded");

   property p_droopOnly;
      @(posedge clk) disable iff (rst)
      DROOP_OPTION |-> (pinCfg[3:0] == 4'h0);
   endproperty
   a_droopOnly: assert property (p_droopOnly) else $error("droop build reassigned");

   property p_identity;
      @(posedge clk) disable iff (rst)
      s_wr(`MCR_CMD_IDENTITY) ##1 s_rd(`MCR_CMD_IDENTITY) |=>
         (rspData[15:2] == {8'h00, MODULE_NAME});
   endproperty
   a_identity: assert property (p_identity) else $error("designation changed");

   property p_pinReserved;
      @(posedge clk) disable iff (rst)
      s_rd(`MCR_CMD_PIN_CFG) |=> (rspData[15:5] == 11'h000) && (rspData[4:0] == $past(pinCfg));
   endproperty
   a_pinReserved: assert property (p_pinReserved) else $error("reserved bits set");

endmodule // mcr_regs
